// >>> hw/psvt_defines.vh
// Behaviour
// - Every bridge port is either client-facing or network-facing, nothing else.
// - Client-facing ports push a service tag on ingress and strip it on egress.
// - Network-facing ports carry the service tag unchanged both ways.
// - Four operation types: push per port, push per port+C-VLAN, mount, mount+S-VLAN.
// - Forwarding uses independent learning with ingress filtering enabled.
// - Per-port push gives every ingress frame the port's preset S-VLAN.
// - Per-port+C-VLAN push maps C-VLAN to S-VLAN; unmapped frames are dropped.
// - One C-VLAN maps to at most one S-VLAN within a port.
// - Per-port mounting skips ingress filter; frames without service tag dropped.
// - Per-port+S-VLAN mounting admits only the preset S-VLAN, then table forwarding.
// - Egress on network-facing ports leaves the service tag untouched.
// - Egress only on ports listed in the filtering entry of the frame S-VLAN.
// - Client port egress S-VLAN is its pushed one; network port its mounted one.
// - Network port mounted per port is member of every legal S-VLAN; code skips its ingress filter but egress still needs its VFT bit.
// - Per-port tag-attribute settings are ignored for client or network ports.
// - Per-port maximum frame length is configurable, default 1522 bytes.
// - Per-port MAC loopback is selectable; reset leaves it off.
// - Per-port PHY loopback is selectable, separate from MAC loopback, off at reset.
`ifndef PSVT_DEFINES_VH
`define PSVT_DEFINES_VH
`define PSVT_VID_W 12
`define PSVT_LEN_W 14
`define PSVT_TPID_W 16
`define PSVT_TPID_STAG 16'h88A8
`define PSVT_TPID_CTAG 16'h8100
`define PSVT_MAXLEN_RST 14'h05F2
`define PSVT_VID_NULL 12'h000
`define PSVT_VID_RSVD 12'hFFF
`define PSVT_OP_W 2
`define PSVT_OP_NET_BIT 1
`define PSVT_OP_PUSH_PORT 2'h0
`define PSVT_OP_PUSH_CVLAN 2'h1
`define PSVT_OP_MOUNT_PORT 2'h2
`define PSVT_OP_MOUNT_SVLAN 2'h3
`define PSVT_RSN_W 3
`define PSVT_RSN_NONE 3'h0
`define PSVT_RSN_OVERSIZE 3'h1
`define PSVT_RSN_NO_MAP 3'h2
`define PSVT_RSN_NO_STAG 3'h3
`define PSVT_RSN_MISMATCH 3'h4
`define PSVT_RSN_INFILTER 3'h5
`define PSVT_RSN_ILLEGAL 3'h6
`define PSVT_CNT_W 16
`endif

// >>> hw/psvt_cmap.v
`timescale 1ns/10ps
`default_nettype none
`include "psvt_defines.vh"
module psvt_cmap #(
  parameter NP = 4,
  parameter PW = 2,
  parameter NE = 8,
  parameter IW = 3
) (
  input wire clk_in,
  input wire rst_b_in,
  input wire wr_en_in,
  input wire [PW-1:0] wr_port_in,
  input wire [IW-1:0] wr_idx_in,
  input wire [`PSVT_VID_W-1:0] wr_cvid_in,
  input wire [`PSVT_VID_W-1:0] wr_svid_in,
  input wire wr_valid_in,
  input wire [PW-1:0] lk_port_in,
  input wire [`PSVT_VID_W-1:0] lk_cvid_in,
  output reg lk_hit_out,
  output reg [`PSVT_VID_W-1:0] lk_svid_out,
  input wire [`PSVT_VID_W-1:0] rev_svid_in,
  output reg [NP-1:0] rev_hit_out
);
  reg vld_reg [0:NP*NE-1];
  reg [`PSVT_VID_W-1:0] cvid_reg [0:NP*NE-1];
  reg [`PSVT_VID_W-1:0] svid_reg [0:NP*NE-1];
  reg hit_next;
  reg [`PSVT_VID_W-1:0] svid_next;
  reg [NP-1:0] rev_next;
  integer k;
  integer p;
  integer e;

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (k = 0; k < NP*NE; k = k + 1) begin
        vld_reg[k] <= 1'b0;
      end
    end else if (wr_en_in) begin
      // Earlier entries with the same client VLAN are cleared by the new write, keeping the map single-valued
      for (k = 0; k < NE; k = k + 1) begin
        if (k != wr_idx_in && cvid_reg[wr_port_in*NE+k] == wr_cvid_in && wr_valid_in) begin
          vld_reg[wr_port_in*NE+k] <= 1'b0;
        end
      end
      vld_reg[wr_port_in*NE+wr_idx_in] <= wr_valid_in;
    end
  end

  // Entry contents need no reset; the valid bits hide stale ones
  always @(posedge clk_in) begin
    if (wr_en_in) begin
      cvid_reg[wr_port_in*NE+wr_idx_in] <= wr_cvid_in;
      svid_reg[wr_port_in*NE+wr_idx_in] <= wr_svid_in;
    end
  end

  always @* begin
    hit_next = 1'b0;
    svid_next = `PSVT_VID_NULL;
    rev_next = {NP{1'b0}};
    for (e = 0; e < NE; e = e + 1) begin
      if (vld_reg[lk_port_in*NE+e] && cvid_reg[lk_port_in*NE+e] == lk_cvid_in) begin
        hit_next = 1'b1;
        svid_next = svid_reg[lk_port_in*NE+e];
      end
    end
    for (p = 0; p < NP; p = p + 1) begin
      for (e = 0; e < NE; e = e + 1) begin
        if (vld_reg[p*NE+e] && svid_reg[p*NE+e] == rev_svid_in) begin
          rev_next[p] = 1'b1;
        end
      end
    end
  end

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lk_hit_out <= 1'b0;
      lk_svid_out <= `PSVT_VID_NULL;
      rev_hit_out <= {NP{1'b0}};
    end else begin
      lk_hit_out <= hit_next;
      lk_svid_out <= svid_next;
      rev_hit_out <= rev_next;
    end
  end
endmodule
`default_nettype wire

// >>> hw/psvt_vft.v
`timescale 1ns/10ps
`default_nettype none
`include "psvt_defines.vh"
module psvt_vft #(
  parameter NP = 4
) (
  input wire clk_in,
  input wire rst_b_in,
  input wire wr_en_in,
  input wire [`PSVT_VID_W-1:0] wr_svid_in,
  input wire [NP-1:0] wr_mask_in,
  input wire wr_valid_in,
  input wire [`PSVT_VID_W-1:0] lk_svid_in,
  output reg [NP-1:0] lk_row_out
);
  reg [NP-1:0] row_mem [0:(1<<`PSVT_VID_W)-1];
  reg [(1<<`PSVT_VID_W)-1:0] vld_reg;

  // Member bits need no reset; the valid vector hides stale rows
  always @(posedge clk_in) begin
    if (wr_en_in) begin
      row_mem[wr_svid_in] <= wr_mask_in;
    end
  end

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      vld_reg <= {(1<<`PSVT_VID_W){1'b0}};
      lk_row_out <= {NP{1'b0}};
    end else begin
      if (wr_en_in) begin
        vld_reg[wr_svid_in] <= wr_valid_in;
      end
      lk_row_out <= vld_reg[lk_svid_in] ? row_mem[lk_svid_in] : {NP{1'b0}};
    end
  end
endmodule
`default_nettype wire

// >>> hw/psvt_bridge.v
`timescale 1ns/10ps
`default_nettype none
`include "psvt_defines.vh"
module psvt_bridge #(
  parameter NP = 4,
  parameter PW = 2,
  parameter NE = 8,
  parameter IW = 3
) (
  input wire clk_in,
  input wire rst_b_in,
  input wire [NP*`PSVT_OP_W-1:0] cfg_op_in,
  input wire [NP*`PSVT_VID_W-1:0] cfg_svid_in,
  input wire [NP-1:0] cfg_mac_lpbk_in,
  input wire [NP-1:0] cfg_phy_lpbk_in,
  input wire len_wr_in,
  input wire [PW-1:0] len_port_in,
  input wire [`PSVT_LEN_W-1:0] len_data_in,
  input wire map_wr_in,
  input wire [PW-1:0] map_port_in,
  input wire [IW-1:0] map_idx_in,
  input wire [`PSVT_VID_W-1:0] map_cvid_in,
  input wire [`PSVT_VID_W-1:0] map_svid_in,
  input wire map_en_in,
  input wire vft_wr_in,
  input wire [`PSVT_VID_W-1:0] vft_svid_in,
  input wire [NP-1:0] vft_mask_in,
  input wire vft_en_in,
  input wire ing_valid_in,
  input wire [PW-1:0] ing_port_in,
  input wire [`PSVT_LEN_W-1:0] ing_len_in,
  input wire [`PSVT_TPID_W-1:0] ing_tpid_in,
  input wire [`PSVT_VID_W-1:0] ing_vid_in,
  output reg dec_valid_out,
  output reg dec_fwd_out,
  output reg [`PSVT_VID_W-1:0] dec_svid_out,
  output reg dec_push_out,
  output reg [`PSVT_TPID_W-1:0] dec_push_tpid_out,
  output reg [NP-1:0] dec_egress_mask_out,
  output reg [NP-1:0] dec_strip_mask_out,
  output reg [`PSVT_RSN_W-1:0] dec_reason_out,
  output reg [NP-1:0] mac_lpbk_out,
  output reg [NP-1:0] phy_lpbk_out,
  output reg [NP*`PSVT_LEN_W-1:0] max_len_out,
  output reg [`PSVT_CNT_W-1:0] fwd_cnt_out,
  output reg [`PSVT_CNT_W-1:0] drop_cnt_out
);
  reg [1:0] rst_sync_reg;
  wire rst_b;
  reg [`PSVT_LEN_W-1:0] max_len_reg [0:NP-1];
  wire [`PSVT_OP_W-1:0] op_w [0:NP-1];
  wire [`PSVT_VID_W-1:0] preset_w [0:NP-1];
  wire [NP-1:0] net_w;

  reg s1_valid_reg;
  reg [PW-1:0] s1_port_reg;
  reg [`PSVT_LEN_W-1:0] s1_len_reg;
  reg [`PSVT_TPID_W-1:0] s1_tpid_reg;
  reg [`PSVT_VID_W-1:0] s1_vid_reg;
  wire map_hit;
  wire [`PSVT_VID_W-1:0] map_svid;

  reg [`PSVT_VID_W-1:0] s1_svid_next;
  reg [`PSVT_RSN_W-1:0] s1_rsn_next;
  reg [`PSVT_OP_W-1:0] s1_op;

  reg s2_valid_reg;
  reg [PW-1:0] s2_port_reg;
  reg [`PSVT_VID_W-1:0] s2_svid_reg;
  reg [`PSVT_RSN_W-1:0] s2_rsn_reg;
  wire [NP-1:0] vft_row;
  wire [NP-1:0] rev_hit;

  reg [NP-1:0] egress_ok;
  reg [`PSVT_OP_W-1:0] s2_op;
  reg [`PSVT_RSN_W-1:0] s2_rsn_next;
  reg [NP-1:0] egress_next;
  reg [NP-1:0] src_bit;
  integer q;

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_b = rst_sync_reg[1];

  genvar g;
  generate
    for (g = 0; g < NP; g = g + 1) begin : port_cfg
      // No tag-attribute input exists, so the operation type alone sets a port's handling
      assign op_w[g] = cfg_op_in[g*`PSVT_OP_W +: `PSVT_OP_W];
      assign preset_w[g] = cfg_svid_in[g*`PSVT_VID_W +: `PSVT_VID_W];
      // Attribute is the top bit of the operation type, so no third kind exists
      assign net_w[g] = op_w[g][`PSVT_OP_NET_BIT];

      always @(posedge clk_in or negedge rst_b) begin
        if (!rst_b) begin
          max_len_reg[g] <= `PSVT_MAXLEN_RST;
        end else if (len_wr_in && len_port_in == g) begin
          max_len_reg[g] <= len_data_in;
        end
      end

      always @(posedge clk_in or negedge rst_b) begin
        if (!rst_b) begin
          max_len_out[g*`PSVT_LEN_W +: `PSVT_LEN_W] <= `PSVT_MAXLEN_RST;
        end else begin
          max_len_out[g*`PSVT_LEN_W +: `PSVT_LEN_W] <= max_len_reg[g];
        end
      end
    end
  endgenerate

  // Loopback selects are handed to the MAC and PHY; both come up off
  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      mac_lpbk_out <= {NP{1'b0}};
      phy_lpbk_out <= {NP{1'b0}};
    end else begin
      mac_lpbk_out <= cfg_mac_lpbk_in;
      phy_lpbk_out <= cfg_phy_lpbk_in;
    end
  end

  psvt_cmap #(
    .NP(NP),
    .PW(PW),
    .NE(NE),
    .IW(IW)
  ) u_cmap (
    .clk_in(clk_in),
    .rst_b_in(rst_b),
    .wr_en_in(map_wr_in),
    .wr_port_in(map_port_in),
    .wr_idx_in(map_idx_in),
    .wr_cvid_in(map_cvid_in),
    .wr_svid_in(map_svid_in),
    .wr_valid_in(map_en_in),
    .lk_port_in(ing_port_in),
    .lk_cvid_in(ing_vid_in),
    .lk_hit_out(map_hit),
    .lk_svid_out(map_svid),
    .rev_svid_in(s1_svid_next),
    .rev_hit_out(rev_hit)
  );

  psvt_vft #(
    .NP(NP)
  ) u_vft (
    .clk_in(clk_in),
    .rst_b_in(rst_b),
    .wr_en_in(vft_wr_in),
    .wr_svid_in(vft_svid_in),
    .wr_mask_in(vft_mask_in),
    .wr_valid_in(vft_en_in),
    .lk_svid_in(s1_svid_next),
    .lk_row_out(vft_row)
  );

  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      s1_valid_reg <= 1'b0;
      s1_port_reg <= {PW{1'b0}};
      s1_len_reg <= {`PSVT_LEN_W{1'b0}};
      s1_tpid_reg <= {`PSVT_TPID_W{1'b0}};
      s1_vid_reg <= `PSVT_VID_NULL;
    end else begin
      s1_valid_reg <= ing_valid_in;
      s1_port_reg <= ing_port_in;
      s1_len_reg <= ing_len_in;
      s1_tpid_reg <= ing_tpid_in;
      s1_vid_reg <= ing_vid_in;
    end
  end

  // Ingress classification: pick the service VLAN and any early discard
  always @* begin
    s1_op = op_w[s1_port_reg];
    s1_svid_next = s1_vid_reg;
    s1_rsn_next = `PSVT_RSN_NONE;
    case (s1_op)
      `PSVT_OP_PUSH_PORT: begin
        s1_svid_next = preset_w[s1_port_reg];
      end
      `PSVT_OP_PUSH_CVLAN: begin
        s1_svid_next = map_svid;
        if (s1_tpid_reg != `PSVT_TPID_CTAG || !map_hit) begin
          s1_rsn_next = `PSVT_RSN_NO_MAP;
        end
      end
      `PSVT_OP_MOUNT_PORT: begin
        if (s1_tpid_reg != `PSVT_TPID_STAG) begin
          s1_rsn_next = `PSVT_RSN_NO_STAG;
        end
      end
      `PSVT_OP_MOUNT_SVLAN: begin
        if (s1_tpid_reg != `PSVT_TPID_STAG) begin
          s1_rsn_next = `PSVT_RSN_NO_STAG;
        end else if (s1_vid_reg != preset_w[s1_port_reg]) begin
          s1_rsn_next = `PSVT_RSN_MISMATCH;
        end
      end
      default: begin
        s1_rsn_next = `PSVT_RSN_ILLEGAL;
      end
    endcase
    if (s1_rsn_next == `PSVT_RSN_NONE &&
        (s1_svid_next == `PSVT_VID_NULL || s1_svid_next == `PSVT_VID_RSVD)) begin
      s1_rsn_next = `PSVT_RSN_ILLEGAL;
    end
    // Length on the wire, tags included, beats every other reason
    if (s1_len_reg > max_len_reg[s1_port_reg]) begin
      s1_rsn_next = `PSVT_RSN_OVERSIZE;
    end
  end

  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      s2_valid_reg <= 1'b0;
      s2_port_reg <= {PW{1'b0}};
      s2_svid_reg <= `PSVT_VID_NULL;
      s2_rsn_reg <= `PSVT_RSN_NONE;
    end else begin
      s2_valid_reg <= s1_valid_reg;
      s2_port_reg <= s1_port_reg;
      s2_svid_reg <= s1_svid_next;
      s2_rsn_reg <= s1_rsn_next;
    end
  end

  // Egress membership and ingress filtering under IVL, filtering on except for a port mounted per port
  always @* begin
    s2_op = op_w[s2_port_reg];
    src_bit = {NP{1'b0}};
    src_bit[s2_port_reg] = 1'b1;
    for (q = 0; q < NP; q = q + 1) begin
      case (op_w[q])
        `PSVT_OP_PUSH_PORT: begin
          egress_ok[q] = (s2_svid_reg == preset_w[q]);
        end
        `PSVT_OP_PUSH_CVLAN: begin
          egress_ok[q] = rev_hit[q];
        end
        `PSVT_OP_MOUNT_PORT: begin
          egress_ok[q] = 1'b1;
        end
        `PSVT_OP_MOUNT_SVLAN: begin
          egress_ok[q] = (s2_svid_reg == preset_w[q]);
        end
        default: begin
          egress_ok[q] = 1'b0;
        end
      endcase
    end
    egress_next = vft_row & egress_ok & ~src_bit;
    s2_rsn_next = s2_rsn_reg;
    if (s2_rsn_reg == `PSVT_RSN_NONE && s2_op != `PSVT_OP_MOUNT_PORT &&
        !vft_row[s2_port_reg]) begin
      s2_rsn_next = `PSVT_RSN_INFILTER;
    end
  end

  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      dec_valid_out <= 1'b0;
      dec_fwd_out <= 1'b0;
      dec_svid_out <= `PSVT_VID_NULL;
      dec_push_out <= 1'b0;
      dec_push_tpid_out <= `PSVT_TPID_STAG;
      dec_egress_mask_out <= {NP{1'b0}};
      dec_strip_mask_out <= {NP{1'b0}};
      dec_reason_out <= `PSVT_RSN_NONE;
      fwd_cnt_out <= {`PSVT_CNT_W{1'b0}};
      drop_cnt_out <= {`PSVT_CNT_W{1'b0}};
    end else begin
      dec_valid_out <= s2_valid_reg;
      dec_svid_out <= s2_svid_reg;
      dec_reason_out <= s2_rsn_next;
      dec_push_tpid_out <= `PSVT_TPID_STAG;
      if (s2_valid_reg && s2_rsn_next == `PSVT_RSN_NONE) begin
        dec_fwd_out <= 1'b1;
        dec_push_out <= ~s2_op[`PSVT_OP_NET_BIT];
        dec_egress_mask_out <= egress_next;
        // Client ports strip, network ports send the tag as received
        dec_strip_mask_out <= egress_next & ~net_w;
        fwd_cnt_out <= fwd_cnt_out + 1'b1;
      end else begin
        dec_fwd_out <= 1'b0;
        dec_push_out <= 1'b0;
        dec_egress_mask_out <= {NP{1'b0}};
        dec_strip_mask_out <= {NP{1'b0}};
        if (s2_valid_reg) begin
          drop_cnt_out <= drop_cnt_out + 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> dv/psvt_bridge_props.sv
`timescale 1ns/10ps
`default_nettype none
`include "psvt_defines.vh"
module psvt_bridge_props #(
  parameter NP = 4,
  parameter PW = 2
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [NP-1:0] cfg_mac_lpbk_in,
  input wire logic [NP-1:0] cfg_phy_lpbk_in,
  input wire logic ing_valid_in,
  input wire logic [PW-1:0] ing_port_in,
  input wire logic [`PSVT_LEN_W-1:0] ing_len_in,
  input wire logic dec_valid_out,
  input wire logic dec_fwd_out,
  input wire logic [`PSVT_VID_W-1:0] dec_svid_out,
  input wire logic dec_push_out,
  input wire logic [`PSVT_TPID_W-1:0] dec_push_tpid_out,
  input wire logic [NP-1:0] dec_egress_mask_out,
  input wire logic [NP-1:0] dec_strip_mask_out,
  input wire logic [`PSVT_RSN_W-1:0] dec_reason_out,
  input wire logic [NP-1:0] mac_lpbk_out,
  input wire logic [NP-1:0] phy_lpbk_out,
  input wire logic [NP*`PSVT_LEN_W-1:0] max_len_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  property p_lat;
    ing_valid_in |-> ##3 dec_valid_out;
  endproperty
  a_lat: assert property (p_lat) else $error("decision missing");
  property p_idle;
    !ing_valid_in |-> ##3 !dec_valid_out;
  endproperty
  a_idle: assert property (p_idle) else $error("decision without frame");
  property p_ovs;
    ing_valid_in && (ing_len_in > max_len_out[ing_port_in*`PSVT_LEN_W +: `PSVT_LEN_W])
      |-> ##3 !dec_fwd_out && dec_reason_out == `PSVT_RSN_OVERSIZE;
  endproperty
  a_ovs: assert property (p_ovs) else $error("oversize frame kept");
  property p_fwd;
    dec_valid_out && dec_fwd_out |-> dec_reason_out == `PSVT_RSN_NONE
      && dec_svid_out != `PSVT_VID_NULL && dec_svid_out != `PSVT_VID_RSVD;
  endproperty
  a_fwd: assert property (p_fwd) else $error("bad forward decision");
  property p_drop;
    dec_valid_out && !dec_fwd_out |-> dec_egress_mask_out == '0 && !dec_push_out
      && dec_reason_out != `PSVT_RSN_NONE;
  endproperty
  a_drop: assert property (p_drop) else $error("dropped frame leaks");
  property p_strip;
    dec_valid_out |-> (dec_strip_mask_out & ~dec_egress_mask_out) == '0
      && !dec_egress_mask_out[$past(ing_port_in, 3)];
  endproperty
  a_strip: assert property (p_strip) else $error("bad egress or strip mask");
  property p_tpid;
    dec_push_tpid_out == `PSVT_TPID_STAG;
  endproperty
  a_tpid: assert property (p_tpid) else $error("wrong pushed tag type");
  property p_mac;
    1'b1 |=> mac_lpbk_out == $past(cfg_mac_lpbk_in);
  endproperty
  a_mac: assert property (p_mac) else $error("mac loopback not followed");
  property p_phy;
    1'b1 |=> phy_lpbk_out == $past(cfg_phy_lpbk_in);
  endproperty
  a_phy: assert property (p_phy) else $error("phy loopback not followed");
endmodule
`default_nettype wire

// >>> dv/psvt_frame_src.sv
`timescale 1ns/10ps
`default_nettype none
module psvt_frame_src (
  input wire logic clk_in,
  output var logic valid_out,
  output var logic [1:0] port_out,
  output var logic [13:0] len_out,
  output var logic [15:0] tpid_out,
  output var logic [11:0] vid_out
);
  initial begin
    valid_out = 1'b0;
    {port_out, len_out, tpid_out, vid_out} = 44'h0;
  end
  // Fields go inverted between frames so a stale value is never mistaken for data
  task automatic idle;
    @(posedge clk_in);
    valid_out <= 1'b0;
    {port_out, len_out, tpid_out, vid_out} <= ~{port_out, len_out, tpid_out, vid_out};
  endtask
  task automatic send(input logic [1:0] p, input logic [13:0] l, input logic [15:0] t,
                      input logic [11:0] v);
    @(posedge clk_in);
    valid_out <= 1'b1;
    {port_out, len_out, tpid_out, vid_out} <= {p, l, t, v};
  endtask
endmodule
`default_nettype wire

// >>> dv/psvt_bridge_tb.sv
`timescale 1ns/10ps
`default_nettype none
module psvt_bridge_tb;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] cfg_op_in = 8'h00;
  logic [47:0] cfg_svid_in = 48'h0;
  logic [3:0] cfg_mac_lpbk_in = 4'h0;
  logic [3:0] cfg_phy_lpbk_in = 4'h0;
  logic len_wr_in = 1'b0;
  logic [1:0] len_port_in = 2'h0;
  logic [13:0] len_data_in = 14'h0;
  logic map_wr_in = 1'b0;
  logic map_en_in = 1'b0;
  logic [1:0] map_port_in = 2'h0;
  logic [2:0] map_idx_in = 3'h0;
  logic [11:0] map_cvid_in = 12'h0;
  logic [11:0] map_svid_in = 12'h0;
  logic vft_wr_in = 1'b0;
  logic vft_en_in = 1'b0;
  logic [11:0] vft_svid_in = 12'h0;
  logic [3:0] vft_mask_in = 4'h0;
  wire ing_valid_in, dec_valid_out, dec_fwd_out, dec_push_out;
  wire [1:0] ing_port_in;
  wire [13:0] ing_len_in;
  wire [15:0] ing_tpid_in, dec_push_tpid_out, fwd_cnt_out, drop_cnt_out;
  wire [11:0] ing_vid_in, dec_svid_out;
  wire [3:0] dec_egress_mask_out, dec_strip_mask_out, mac_lpbk_out, phy_lpbk_out;
  wire [2:0] dec_reason_out;
  wire [55:0] max_len_out;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  int n_ok = 0;
  int n_dr = 0;
  logic [24:0] q[$];
  logic [24:0] e;

  always #50 clk_in = ~clk_in;

  psvt_frame_src i_src (.clk_in(clk_in), .valid_out(ing_valid_in), .port_out(ing_port_in),
    .len_out(ing_len_in), .tpid_out(ing_tpid_in), .vid_out(ing_vid_in));

  psvt_bridge i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .cfg_op_in(cfg_op_in),
    .cfg_svid_in(cfg_svid_in), .cfg_mac_lpbk_in(cfg_mac_lpbk_in),
    .cfg_phy_lpbk_in(cfg_phy_lpbk_in), .len_wr_in(len_wr_in), .len_port_in(len_port_in),
    .len_data_in(len_data_in), .map_wr_in(map_wr_in), .map_port_in(map_port_in),
    .map_idx_in(map_idx_in), .map_cvid_in(map_cvid_in), .map_svid_in(map_svid_in),
    .map_en_in(map_en_in), .vft_wr_in(vft_wr_in), .vft_svid_in(vft_svid_in),
    .vft_mask_in(vft_mask_in), .vft_en_in(vft_en_in), .ing_valid_in(ing_valid_in),
    .ing_port_in(ing_port_in), .ing_len_in(ing_len_in), .ing_tpid_in(ing_tpid_in),
    .ing_vid_in(ing_vid_in), .dec_valid_out(dec_valid_out), .dec_fwd_out(dec_fwd_out),
    .dec_svid_out(dec_svid_out), .dec_push_out(dec_push_out),
    .dec_push_tpid_out(dec_push_tpid_out), .dec_egress_mask_out(dec_egress_mask_out),
    .dec_strip_mask_out(dec_strip_mask_out), .dec_reason_out(dec_reason_out),
    .mac_lpbk_out(mac_lpbk_out), .phy_lpbk_out(phy_lpbk_out), .max_len_out(max_len_out),
    .fwd_cnt_out(fwd_cnt_out), .drop_cnt_out(drop_cnt_out));

  task automatic complete_run;
    if (miscompares == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [55:0] g, input logic [55:0] x);
    comparisons++;
    if (g !== x) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, g, x);
    end
  endtask

  task automatic fr(input logic [1:0] p, input logic [13:0] l, input logic [15:0] t,
                    input logic [11:0] v, input logic [24:0] x);
    q.push_back(x);
    i_src.send(p, l, t, v);
  endtask

  task automatic ok(input logic [1:0] p, input logic [13:0] l, input logic [15:0] t,
                    input logic [11:0] v, input logic [11:0] s, input logic pu,
                    input logic [3:0] eg, input logic [3:0] st);
    n_ok++;
    fr(p, l, t, v, {1'b1, s, pu, eg, st, 3'h0});
  endtask

  task automatic dr(input logic [1:0] p, input logic [13:0] l, input logic [15:0] t,
                    input logic [11:0] v, input logic [2:0] r);
    n_dr++;
    fr(p, l, t, v, {22'h0, r});
  endtask

  task automatic wmap(input logic [2:0] i, input logic [11:0] c, input logic [11:0] s);
    @(posedge clk_in);
    {map_wr_in, map_en_in, map_port_in} <= 4'hD;
    {map_idx_in, map_cvid_in, map_svid_in} <= {i, c, s};
    @(posedge clk_in);
    map_wr_in <= 1'b0;
  endtask

  task automatic wvft(input logic [11:0] s, input logic [3:0] m);
    @(posedge clk_in);
    {vft_wr_in, vft_en_in, vft_svid_in, vft_mask_in} <= {2'h3, s, m};
    @(posedge clk_in);
    vft_wr_in <= 1'b0;
  endtask

  // Drops do not define the service VLAN, so it is only compared on forwards
  always @(posedge clk_in) begin
    if (dec_valid_out === 1'b1) begin
      e = q.size() > 0 ? q.pop_front() : 25'h1FFFFFF;
      cmp({dec_fwd_out, e[24] ? dec_svid_out : e[23:12], dec_push_out,
           dec_egress_mask_out, dec_strip_mask_out, dec_reason_out}, e);
    end
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      $display("[ERR] %0t timeout", $time);
      complete_run;
    end
  end

  initial begin
    repeat (12) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    cmp(max_len_out, {4{14'h05F2}});
    cmp({mac_lpbk_out, phy_lpbk_out}, 8'h00);
    cfg_op_in <= 8'hE4;
    cfg_svid_in <= {12'h064, 24'h0, 12'h064};
    wmap(3'h0, 12'h00A, 12'h0C8);
    wmap(3'h1, 12'h01E, 12'h064);
    wvft(12'h064, 4'hF);
    wvft(12'h0C8, 4'h6);
    ok(2'h0, 14'h064, 16'h8100, 12'h005, 12'h064, 1'b1, 4'hE, 4'h2);
    ok(2'h1, 14'h064, 16'h8100, 12'h00A, 12'h0C8, 1'b1, 4'h4, 4'h0);
    dr(2'h1, 14'h064, 16'h8100, 12'h063, 3'h2);
    dr(2'h1, 14'h064, 16'h88A8, 12'h00A, 3'h2);
    ok(2'h2, 14'h064, 16'h88A8, 12'h0C8, 12'h0C8, 1'b0, 4'h2, 4'h2);
    ok(2'h3, 14'h064, 16'h88A8, 12'h064, 12'h064, 1'b0, 4'h7, 4'h3);
    dr(2'h2, 14'h064, 16'h8100, 12'h064, 3'h3);
    dr(2'h3, 14'h064, 16'h88A8, 12'h0C8, 3'h4);
    ok(2'h2, 14'h064, 16'h88A8, 12'h12C, 12'h12C, 1'b0, 4'h0, 4'h0);
    ok(2'h0, 14'h05F2, 16'h8100, 12'h005, 12'h064, 1'b1, 4'hE, 4'h2);
    dr(2'h0, 14'h05F3, 16'h8100, 12'h005, 3'h1);
    dr(2'h2, 14'h064, 16'h88A8, 12'h000, 3'h6);
    i_src.idle;
    repeat (6) @(posedge clk_in);
    cfg_svid_in[11:0] <= 12'h12C;
    repeat (2) @(posedge clk_in);
    dr(2'h0, 14'h064, 16'h8100, 12'h005, 3'h5);
    i_src.idle;
    repeat (4) @(posedge clk_in);
    cfg_svid_in[11:0] <= 12'h064;
    {len_wr_in, len_port_in, len_data_in} <= {3'h4, 14'h0040};
    @(posedge clk_in);
    len_wr_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    cmp(max_len_out, {{3{14'h05F2}}, 14'h0040});
    dr(2'h0, 14'h0041, 16'h8100, 12'h005, 3'h1);
    ok(2'h0, 14'h0040, 16'h8100, 12'h005, 12'h064, 1'b1, 4'hE, 4'h2);
    i_src.idle;
    wmap(3'h2, 12'h00A, 12'h064);
    ok(2'h1, 14'h064, 16'h8100, 12'h00A, 12'h064, 1'b1, 4'hD, 4'h1);
    ok(2'h2, 14'h064, 16'h88A8, 12'h0C8, 12'h0C8, 1'b0, 4'h0, 4'h0);
    i_src.idle;
    repeat (6) @(posedge clk_in);
    cfg_mac_lpbk_in <= 4'hA;
    cfg_phy_lpbk_in <= 4'h5;
    repeat (3) @(posedge clk_in);
    cmp({mac_lpbk_out, phy_lpbk_out}, 8'hA5);
    cmp(q.size(), 0);
    cmp({fwd_cnt_out, drop_cnt_out}, {n_ok[15:0], n_dr[15:0]});
    complete_run;
  end
endmodule

bind psvt_bridge psvt_bridge_props #(.NP(NP), .PW(PW)) i_props (.clk_in(clk_in),
  .rst_b_in(rst_b_in), .cfg_mac_lpbk_in(cfg_mac_lpbk_in), .cfg_phy_lpbk_in(cfg_phy_lpbk_in),
  .ing_valid_in(ing_valid_in), .ing_port_in(ing_port_in), .ing_len_in(ing_len_in),
  .dec_valid_out(dec_valid_out), .dec_fwd_out(dec_fwd_out), .dec_svid_out(dec_svid_out),
  .dec_push_out(dec_push_out), .dec_push_tpid_out(dec_push_tpid_out),
  .dec_egress_mask_out(dec_egress_mask_out), .dec_strip_mask_out(dec_strip_mask_out),
  .dec_reason_out(dec_reason_out), .mac_lpbk_out(mac_lpbk_out),
  .phy_lpbk_out(phy_lpbk_out), .max_len_out(max_len_out));
`default_nettype wire
